//--- verilog/cfg_pkg.sv
/*
 * Shared constants, types and helpers for the configuration word
 * decoder: register map, field positions, codes and decoded bundles.
 * Assumes a 14-bit configuration word and a 2-bit register address.
 */
package cfg_pkg;

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam int WORD_W = 14;
  localparam int ADDR_W = 2;
  localparam logic [1:0] ADDR_WDOG_WORD = 2'h0;
  localparam logic [1:0] ADDR_MEM_WORD = 2'h1;
  localparam logic [1:0] ADDR_WDOG_CTRL = 2'h2;
  localparam logic [1:0] ADDR_STATUS = 2'h3;
  localparam logic [13:0] ERASED_WORD = 14'h3fff;
  localparam logic [13:0] CTRL_RESET = 14'h0000;
  localparam logic [13:0] ZERO_WORD = 14'h0000;

  // ------------------------------------------------------------
  // watchdog word layout and codes
  // ------------------------------------------------------------
  localparam int WD_CLK_LSB = 11;
  localparam int WD_WIN_LSB = 8;
  localparam int WD_MODE_LSB = 5;
  localparam int WD_PER_LSB = 0;
  localparam logic [13:0] WD_UNIMPL_MASK = 14'h0080;
  localparam logic [2:0] CLK_MID_FREQ = 3'h0;
  localparam logic [2:0] CLK_LOW_FREQ = 3'h1;
  localparam logic [2:0] CLK_SOFT = 3'h7;
  localparam logic [2:0] WIN_SOFT_MIN = 3'h6;
  localparam logic [2:0] WIN_FULL_OPEN = 3'h7;
  localparam logic [4:0] PER_SOFT = 5'h1f;
  localparam logic [4:0] PER_SOFT_LOAD = 5'h0b;
  localparam logic [4:0] PER_MAX_CODE = 5'h12;
  localparam logic [4:0] DIV_EXP_BASE = 5'h05;

  typedef enum logic [1:0] {
    MODE_OFF = 2'b00,
    MODE_SOFT = 2'b01,
    MODE_AWAKE = 2'b10,
    MODE_ALWAYS = 2'b11
  } wdog_mode_e;

  // ------------------------------------------------------------
  // memory word layout and codes
  // ------------------------------------------------------------
  localparam int MEM_LVP_BIT = 13;
  localparam int MEM_SAF_WP_BIT = 11;
  localparam int MEM_CFG_WP_BIT = 9;
  localparam int MEM_BOOT_WP_BIT = 8;
  localparam int MEM_APP_WP_BIT = 7;
  localparam int MEM_SAF_EN_BIT = 4;
  localparam int MEM_BOOT_EN_BIT = 3;
  localparam int MEM_BOOT_SIZE_LSB = 0;
  localparam logic [13:0] MEM_UNIMPL_MASK = 14'h1460;
  localparam logic [13:0] MEM_STICKY_MASK = 14'h0b98;
  localparam logic [13:0] MEM_SIZE_MASK = 14'h0007;
  localparam logic SAF_PRESENT = 1'b1;
  localparam logic [2:0] BOOT_SMALL_CODE = 3'h7;
  localparam logic [11:0] BOOT_WORDS_SMALL = 12'h200;
  localparam logic [11:0] BOOT_WORDS_LARGE = 12'h400;
  localparam logic [11:0] PROG_MEM_WORDS = 12'h800;

  // ------------------------------------------------------------
  // control and status layout
  // ------------------------------------------------------------
  localparam int CTRL_SOFT_EN_BIT = 0;
  localparam int CTRL_PER_LSB = 1;
  localparam int CTRL_WIN_LSB = 6;
  localparam int CTRL_CLK_LSB = 9;
  localparam int ST_READY_BIT = 0;
  localparam int ST_KEYED_BIT = 1;
  localparam int ST_RUN_BIT = 2;
  localparam int ST_CLK_RES_BIT = 3;
  localparam int ST_REFUSED_BIT = 4;

  typedef enum logic [1:0] {
    LOAD_IDLE = 2'b00,
    LOAD_COPY = 2'b01,
    LOAD_RUN = 2'b10
  } load_state_e;

  typedef struct packed {
    logic [2:0] clk_sel;
    logic [2:0] win;
    logic [1:0] mode;
    logic [4:0] period;
  } wdog_cfg_s;

  typedef struct packed {
    logic [2:0] win_load;
    logic [4:0] per_load;
    logic win_sw_ok;
    logic per_sw_ok;
    logic clk_soft;
    logic clk_reserved;
  } wdog_dec_s;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [13:0] fill_unimpl(input logic [13:0] w,
                                              input logic [13:0] m);
    fill_unimpl = w | m;
  endfunction

  function automatic logic [4:0] div_exp(input logic [4:0] code);
    if (code > PER_MAX_CODE) begin
      div_exp = DIV_EXP_BASE;
    end else begin
      div_exp = DIV_EXP_BASE + code;
    end
  endfunction

endpackage

//--- verilog/wdog_word_decode.sv
/*
 * Combinational decode of the watchdog configuration word: values
 * loaded at power-on and which runtime fields software may change.
 * Assumes the caller registers the results.
 */
`timescale 1ns/10ps
module wdog_word_decode (
  // configured fields
  input wire cfg_pkg::wdog_cfg_s cfg,
  // decoded results
  output cfg_pkg::wdog_dec_s dec
);

  always_comb begin
    dec = '0;
    // open window codes hand the field to software
    if (cfg.win >= cfg_pkg::WIN_SOFT_MIN) begin
      dec.win_load = cfg_pkg::WIN_FULL_OPEN;
      dec.win_sw_ok = 1'b1;
    end else begin
      dec.win_load = cfg.win;
      dec.win_sw_ok = 1'b0;
    end
    if (cfg.period == cfg_pkg::PER_SOFT) begin
      dec.per_load = cfg_pkg::PER_SOFT_LOAD;
      dec.per_sw_ok = 1'b1;
    end else begin
      dec.per_load = cfg.period;
      dec.per_sw_ok = 1'b0;
    end
    dec.clk_soft = (cfg.clk_sel == cfg_pkg::CLK_SOFT);
    dec.clk_reserved = (cfg.clk_sel != cfg_pkg::CLK_SOFT) &&
                       (cfg.clk_sel != cfg_pkg::CLK_LOW_FREQ) &&
                       (cfg.clk_sel != cfg_pkg::CLK_MID_FREQ);
  end

endmodule

//--- verilog/boot_block_decode.sv
/*
 * Boot block size and last address from the enable and size field.
 * Assumes the user program memory size given in the package.
 */
`timescale 1ns/10ps
module boot_block_decode (
  // configured fields
  input wire logic boot_block_enable_n,
  input wire logic [2:0] boot_block_size,
  // decoded results
  output logic [11:0] boot_words,
  output logic [11:0] boot_last
);

  logic [11:0] sel_words;
  logic [11:0] half_words;

  always_comb begin
    half_words = cfg_pkg::PROG_MEM_WORDS >> 1;
    if (boot_block_size == cfg_pkg::BOOT_SMALL_CODE) begin
      sel_words = cfg_pkg::BOOT_WORDS_SMALL;
    end else begin
      sel_words = cfg_pkg::BOOT_WORDS_LARGE;
    end
    if (boot_block_enable_n) begin
      boot_words = 12'h000;
    end else if (sel_words > half_words) begin
      boot_words = half_words;
    end else begin
      boot_words = sel_words;
    end
    if (boot_words == 12'h000) begin
      boot_last = 12'h000;
    end else begin
      boot_last = boot_words - 12'h001;
    end
  end

endmodule

//--- verilog/config_word_wdog_memprot_decode.sv
/*
 * Holds the watchdog and memory configuration words, loads the
 * runtime watchdog fields after reset and drives the decoded
 * settings. Assumes one clock, writes from a programmer or from
 * software flagged by wr_self, and a bulk erase pulse.
 */
// How it works
// - clock select: 001 low, 000 mid, 111 software
// - window 11x: fully open, software owned, unkeyed
// - window 101..000 copied at reset, locked, keyed
// - mode 11 always, 10 awake only
// - mode 01 follows soft enable, 00 off
// - period code up to 10010 sets divider two to 5+code, above it to 5
// - period 11111 loads 01011, software may change
// - erased period field is all ones
// - low-voltage bit selects master clear and programming
// - refuse clearing low-voltage bit during such programming
// - write-protect bits protect when zero
// - storage write protect needs storage enabled
// - boot write protect needs boot block enabled
// - storage enable low turns storage on
// - boot enable high gives zero size
// - size used when enabled, writable only disabled
// - size 111 gives 512, else 1024 words
// - boot block clamped to half of memory
// - protection bits sticky until bulk erase or reset
// - unimplemented bits read as one
// - settings valid before software runs
`timescale 1ns/10ps
module config_word_wdog_memprot_decode (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // register port
  input wire logic [1:0] addr,
  input wire logic [13:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic wr_self,
  output logic [13:0] rdata,
  // programming and system state
  input wire logic bulk_erase,
  input wire logic lvp_prog_active,
  input wire logic master_clear_pin_enable,
  input wire logic sleep,
  // core hold
  output logic cfg_ready,
  // watchdog settings
  output logic wdog_run,
  output logic [2:0] wdog_clock_select,
  output logic wdog_clk_reserved,
  output logic [2:0] wdog_window_runtime,
  output logic wdog_keyed_access,
  output logic [4:0] wdog_period_runtime,
  output logic [4:0] wdog_div_exp,
  // memory settings
  output logic low_volt_program_enable,
  output logic master_clear_pin_active,
  output logic hv_program_required,
  output logic config_write_protect,
  output logic app_block_write_protect,
  output logic storage_area_flash_on,
  output logic storage_area_write_protect,
  output logic boot_block_on,
  output logic boot_block_write_protect,
  output logic [11:0] boot_block_words,
  output logic [11:0] boot_block_last
);

  // ------------------------------------------------------------
  // storage and decode wiring
  // ------------------------------------------------------------
  logic [13:0] config_word_watchdog_r;
  logic [13:0] config_word_memory_r;
  logic [13:0] config_word_watchdog_nxt;
  logic [13:0] config_word_memory_nxt;
  logic wdog_soft_enable_r;
  logic [2:0] soft_clk_sel_r;
  logic [2:0] win_rt_r;
  logic [4:0] per_rt_r;
  logic refused_r;
  cfg_pkg::load_state_e load_state_r;
  cfg_pkg::wdog_cfg_s wcfg;
  cfg_pkg::wdog_dec_s wdec;
  logic [11:0] boot_words_w;
  logic [11:0] boot_last_w;
  logic wr_cfg_ok;
  logic lvp_refuse;
  logic [13:0] mem_word_rd;
  logic [13:0] wdog_word_rd;
  logic [13:0] ctrl_rd;
  logic [13:0] status_rd;
  logic [2:0] clk_eff;
  logic run_eff;

  // unimplemented bit 7 sits between window and mode
  assign wcfg = {config_word_watchdog_r[13:cfg_pkg::WD_WIN_LSB],
                 config_word_watchdog_r[cfg_pkg::WD_MODE_LSB + 1:0]};
  assign wdog_word_rd = cfg_pkg::fill_unimpl(config_word_watchdog_r,
                                             cfg_pkg::WD_UNIMPL_MASK);
  assign mem_word_rd = cfg_pkg::fill_unimpl(config_word_memory_r,
                                            cfg_pkg::MEM_UNIMPL_MASK);

  wdog_word_decode u_wdog_dec (
    .cfg(wcfg),
    .dec(wdec)
  );

  boot_block_decode u_boot_dec (
    .boot_block_enable_n(config_word_memory_r[cfg_pkg::MEM_BOOT_EN_BIT]),
    .boot_block_size(config_word_memory_r[cfg_pkg::MEM_BOOT_SIZE_LSB +: 3]),
    .boot_words(boot_words_w),
    .boot_last(boot_last_w)
  );

  // ------------------------------------------------------------
  // write qualification
  // ------------------------------------------------------------
  // self-writes blocked while configuration write protect is active
  assign wr_cfg_ok = wr &&
    !(wr_self && !config_word_memory_r[cfg_pkg::MEM_CFG_WP_BIT]);
  assign lvp_refuse = lvp_prog_active &&
    !wdata[cfg_pkg::MEM_LVP_BIT];

  always_comb begin
    config_word_watchdog_nxt = cfg_pkg::fill_unimpl(wdata,
                                 cfg_pkg::WD_UNIMPL_MASK);
  end

  always_comb begin
    config_word_memory_nxt = wdata;
    // sticky bits only move toward zero, i.e. protected or enabled
    config_word_memory_nxt = (config_word_memory_r & wdata &
                              cfg_pkg::MEM_STICKY_MASK) |
                             (wdata & ~cfg_pkg::MEM_STICKY_MASK);
    if (!config_word_memory_r[cfg_pkg::MEM_BOOT_EN_BIT]) begin
      config_word_memory_nxt[cfg_pkg::MEM_BOOT_SIZE_LSB +: 3] =
        config_word_memory_r[cfg_pkg::MEM_BOOT_SIZE_LSB +: 3];
    end
    if (lvp_refuse) begin
      config_word_memory_nxt[cfg_pkg::MEM_LVP_BIT] =
        config_word_memory_r[cfg_pkg::MEM_LVP_BIT];
    end
    if (!cfg_pkg::SAF_PRESENT) begin
      config_word_memory_nxt[cfg_pkg::MEM_SAF_WP_BIT] = 1'b1;
    end
    config_word_memory_nxt = cfg_pkg::fill_unimpl(config_word_memory_nxt,
                               cfg_pkg::MEM_UNIMPL_MASK);
  end

  // ------------------------------------------------------------
  // nonvolatile words
  // ------------------------------------------------------------
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      config_word_watchdog_r <= cfg_pkg::ERASED_WORD;
    end else if (bulk_erase) begin
      config_word_watchdog_r <= cfg_pkg::ERASED_WORD;
    end else if (wr_cfg_ok && addr == cfg_pkg::ADDR_WDOG_WORD) begin
      config_word_watchdog_r <= config_word_watchdog_nxt;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      config_word_memory_r <= cfg_pkg::ERASED_WORD;
    end else if (bulk_erase) begin
      config_word_memory_r <= cfg_pkg::ERASED_WORD;
    end else if (wr_cfg_ok && addr == cfg_pkg::ADDR_MEM_WORD) begin
      config_word_memory_r <= config_word_memory_nxt;
    end
  end

  // refused write flag, set wins over the read that clears it
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      refused_r <= 1'b0;
    end else if ((wr && !wr_cfg_ok &&
                  addr != cfg_pkg::ADDR_WDOG_CTRL) ||
                 (wr_cfg_ok && addr == cfg_pkg::ADDR_MEM_WORD &&
                  lvp_refuse)) begin
      refused_r <= 1'b1;
    end else if (rd && addr == cfg_pkg::ADDR_STATUS) begin
      refused_r <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // power-on load sequence
  // ------------------------------------------------------------
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      load_state_r <= cfg_pkg::LOAD_IDLE;
    end else begin
      unique case (load_state_r)
        cfg_pkg::LOAD_IDLE: load_state_r <= cfg_pkg::LOAD_COPY;
        cfg_pkg::LOAD_COPY: load_state_r <= cfg_pkg::LOAD_RUN;
        cfg_pkg::LOAD_RUN: load_state_r <= cfg_pkg::LOAD_RUN;
        default: load_state_r <= cfg_pkg::LOAD_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      cfg_ready <= 1'b0;
    end else begin
      cfg_ready <= (load_state_r == cfg_pkg::LOAD_RUN);
    end
  end

  // ------------------------------------------------------------
  // runtime watchdog fields
  // ------------------------------------------------------------
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      win_rt_r <= cfg_pkg::WIN_FULL_OPEN;
    end else if (load_state_r == cfg_pkg::LOAD_COPY) begin
      win_rt_r <= wdec.win_load;
    end else if (wr && addr == cfg_pkg::ADDR_WDOG_CTRL &&
                 wdec.win_sw_ok) begin
      win_rt_r <= wdata[cfg_pkg::CTRL_WIN_LSB +: 3];
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      per_rt_r <= cfg_pkg::PER_SOFT_LOAD;
    end else if (load_state_r == cfg_pkg::LOAD_COPY) begin
      per_rt_r <= wdec.per_load;
    end else if (wr && addr == cfg_pkg::ADDR_WDOG_CTRL &&
                 wdec.per_sw_ok) begin
      per_rt_r <= wdata[cfg_pkg::CTRL_PER_LSB +: 5];
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      wdog_soft_enable_r <= cfg_pkg::CTRL_RESET[cfg_pkg::CTRL_SOFT_EN_BIT];
      soft_clk_sel_r <= cfg_pkg::CTRL_RESET[cfg_pkg::CTRL_CLK_LSB +: 3];
    end else if (wr && addr == cfg_pkg::ADDR_WDOG_CTRL) begin
      wdog_soft_enable_r <= wdata[cfg_pkg::CTRL_SOFT_EN_BIT];
      soft_clk_sel_r <= wdata[cfg_pkg::CTRL_CLK_LSB +: 3];
    end
  end

  // ------------------------------------------------------------
  // watchdog decode
  // ------------------------------------------------------------
  always_comb begin
    if (wdec.clk_soft) begin
      clk_eff = soft_clk_sel_r;
    end else begin
      clk_eff = wcfg.clk_sel;
    end
    unique case (cfg_pkg::wdog_mode_e'(wcfg.mode))
      cfg_pkg::MODE_ALWAYS: run_eff = 1'b1;
      cfg_pkg::MODE_AWAKE: run_eff = !sleep;
      cfg_pkg::MODE_SOFT: run_eff = wdog_soft_enable_r;
      cfg_pkg::MODE_OFF: run_eff = 1'b0;
    endcase
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      wdog_run <= 1'b0;
      wdog_clock_select <= cfg_pkg::CLK_MID_FREQ;
      wdog_clk_reserved <= 1'b0;
      wdog_window_runtime <= cfg_pkg::WIN_FULL_OPEN;
      wdog_keyed_access <= 1'b0;
      wdog_period_runtime <= cfg_pkg::PER_SOFT_LOAD;
      wdog_div_exp <= cfg_pkg::DIV_EXP_BASE;
    end else begin
      wdog_run <= run_eff && (load_state_r == cfg_pkg::LOAD_RUN);
      wdog_clock_select <= clk_eff;
      wdog_clk_reserved <= wdec.clk_reserved;
      wdog_window_runtime <= win_rt_r;
      wdog_keyed_access <= !wdec.win_sw_ok;
      wdog_period_runtime <= per_rt_r;
      wdog_div_exp <= cfg_pkg::div_exp(per_rt_r);
    end
  end

  // ------------------------------------------------------------
  // memory decode
  // ------------------------------------------------------------
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      low_volt_program_enable <= 1'b1;
      master_clear_pin_active <= 1'b1;
      hv_program_required <= 1'b0;
      config_write_protect <= 1'b0;
      app_block_write_protect <= 1'b0;
      storage_area_flash_on <= 1'b0;
      storage_area_write_protect <= 1'b0;
      boot_block_on <= 1'b0;
      boot_block_write_protect <= 1'b0;
      boot_block_words <= 12'h000;
      boot_block_last <= 12'h000;
    end else begin
      low_volt_program_enable <=
        config_word_memory_r[cfg_pkg::MEM_LVP_BIT];
      master_clear_pin_active <=
        config_word_memory_r[cfg_pkg::MEM_LVP_BIT] ||
        master_clear_pin_enable;
      hv_program_required <=
        !config_word_memory_r[cfg_pkg::MEM_LVP_BIT];
      config_write_protect <=
        !config_word_memory_r[cfg_pkg::MEM_CFG_WP_BIT];
      app_block_write_protect <=
        !config_word_memory_r[cfg_pkg::MEM_APP_WP_BIT];
      storage_area_flash_on <= cfg_pkg::SAF_PRESENT &&
        !config_word_memory_r[cfg_pkg::MEM_SAF_EN_BIT];
      storage_area_write_protect <= cfg_pkg::SAF_PRESENT &&
        !config_word_memory_r[cfg_pkg::MEM_SAF_EN_BIT] &&
        !config_word_memory_r[cfg_pkg::MEM_SAF_WP_BIT];
      boot_block_on <=
        !config_word_memory_r[cfg_pkg::MEM_BOOT_EN_BIT];
      boot_block_write_protect <=
        !config_word_memory_r[cfg_pkg::MEM_BOOT_EN_BIT] &&
        !config_word_memory_r[cfg_pkg::MEM_BOOT_WP_BIT];
      boot_block_words <= boot_words_w;
      boot_block_last <= boot_last_w;
    end
  end

  // ------------------------------------------------------------
  // read port
  // ------------------------------------------------------------
  always_comb begin
    ctrl_rd = cfg_pkg::ZERO_WORD;
    ctrl_rd[cfg_pkg::CTRL_SOFT_EN_BIT] = wdog_soft_enable_r;
    ctrl_rd[cfg_pkg::CTRL_PER_LSB +: 5] = per_rt_r;
    ctrl_rd[cfg_pkg::CTRL_WIN_LSB +: 3] = win_rt_r;
    ctrl_rd[cfg_pkg::CTRL_CLK_LSB +: 3] = soft_clk_sel_r;
    status_rd = cfg_pkg::ZERO_WORD;
    status_rd[cfg_pkg::ST_READY_BIT] = cfg_ready;
    status_rd[cfg_pkg::ST_KEYED_BIT] = wdog_keyed_access;
    status_rd[cfg_pkg::ST_RUN_BIT] = wdog_run;
    status_rd[cfg_pkg::ST_CLK_RES_BIT] = wdog_clk_reserved;
    status_rd[cfg_pkg::ST_REFUSED_BIT] = refused_r;
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      rdata <= cfg_pkg::ZERO_WORD;
    end else if (rd) begin
      unique case (addr)
        cfg_pkg::ADDR_WDOG_WORD: rdata <= wdog_word_rd;
        cfg_pkg::ADDR_MEM_WORD: rdata <= mem_word_rd;
        cfg_pkg::ADDR_WDOG_CTRL: rdata <= ctrl_rd;
        cfg_pkg::ADDR_STATUS: rdata <= status_rd;
      endcase
    end else begin
      rdata <= cfg_pkg::ZERO_WORD;
    end
  end

endmodule

//--- bench/cfg_word_sva.sv
/*
 * Checker: assertions on the configuration word decoder outputs.
 * Assumes it is bound to the decoder top and sees its ports only.
 */
`timescale 1ns/10ps
module cfg_word_sva (
  // clock, reset and register port
  input wire logic mclk,
  input wire logic reset,
  input wire logic [1:0] addr,
  input wire logic rd,
  input wire logic [13:0] rdata,
  // decoded settings
  input wire logic cfg_ready,
  input wire logic [4:0] wdog_period_runtime,
  input wire logic [4:0] wdog_div_exp,
  input wire logic low_volt_program_enable,
  input wire logic master_clear_pin_active,
  input wire logic hv_program_required,
  input wire logic storage_area_flash_on,
  input wire logic storage_area_write_protect,
  input wire logic boot_block_on,
  input wire logic boot_block_write_protect,
  input wire logic [11:0] boot_block_words,
  input wire logic [11:0] boot_block_last
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  ready_load_a:
    assert property ($fell(reset) |-> !cfg_ready ##[1:4] cfg_ready)
    else $error("settings not ready in time");
  div_exp_a:
    assert property (cfg_ready && $stable(wdog_period_runtime) |->
      wdog_div_exp == ((wdog_period_runtime > 5'h12) ? 5'h05 :
      wdog_period_runtime + 5'h05)) else $error("divider mismatch");
  hv_prog_a:
    assert property (hv_program_required != low_volt_program_enable)
    else $error("programming voltage mismatch");
  master_clear_pin_on_a:
    assert property (low_volt_program_enable |-> master_clear_pin_active)
    else $error("master clear not active");
  saf_protect_a:
    assert property (storage_area_write_protect |-> storage_area_flash_on)
    else $error("storage protect while off");
  boot_protect_a:
    assert property (boot_block_write_protect |-> boot_block_on)
    else $error("boot protect while off");
  boot_zero_a:
    assert property (!boot_block_on |-> boot_block_words == 12'h000)
    else $error("disabled boot block has size");
  boot_size_a:
    assert property (boot_block_on |-> boot_block_last ==
      boot_block_words - 12'h001 && boot_block_words inside {12'h200,
      12'h400}) else $error("boot size mismatch");
  unimpl_ones_a:
    assert property ($past(rd) && $past(addr) == 2'h1 |->
      &{rdata[12], rdata[10], rdata[6], rdata[5]})
    else $error("unimplemented bit read zero");
endmodule

bind config_word_wdog_memprot_decode cfg_word_sva cfg_word_sva_i (.*);

//--- bench/tb_top.sv
/*
 * Testbench: register accesses with expected decode results.
 * Assumes the decoder top and package compiled before it.
 */
`timescale 1ns/10ps
module tb_top;
  // ------------------------------------------------------------
  // signals and tasks
  // ------------------------------------------------------------
  logic mclk = 1'b0, reset = 1'b1, wr = 1'b0, rd = 1'b0, wr_self = 1'b0;
  logic bulk_erase = 1'b0, lvp_prog_active = 1'b0, sleep = 1'b0;
  logic master_clear_pin_enable = 1'b0;
  logic [1:0] addr = 2'h0;
  logic [13:0] wdata = 14'h0000, rdata, ex;
  logic cfg_ready, wdog_run, wdog_clk_reserved, wdog_keyed_access, x;
  logic [2:0] wdog_clock_select, wdog_window_runtime;
  logic [4:0] wdog_period_runtime, wdog_div_exp;
  logic low_volt_program_enable, master_clear_pin_active;
  logic hv_program_required, config_write_protect, app_block_write_protect;
  logic storage_area_flash_on, storage_area_write_protect, boot_block_on;
  logic boot_block_write_protect;
  logic [11:0] boot_block_words, boot_block_last;
  int bad_count = 0, samples_checked = 0, n, m, s, e, c;
  wire [13:0] wd_v = {wdog_window_runtime, wdog_period_runtime,
    wdog_div_exp, wdog_run};
  wire [13:0] bb_v = {boot_block_on, boot_block_write_protect,
    boot_block_words};
  wire [13:0] ck_v = {10'h000, wdog_clk_reserved, wdog_clock_select};
  wire [13:0] mf_v = {7'h00, low_volt_program_enable,
    master_clear_pin_active, hv_program_required, config_write_protect,
    app_block_write_protect, storage_area_flash_on,
    storage_area_write_protect};

  config_word_wdog_memprot_decode config_word_wdog_memprot_decode_i (.*);

  always #50 mclk = ~mclk;

  task automatic chk(input string what, input logic [13:0] exp_v,
                     input logic [13:0] got);
    samples_checked++;
    if (got !== exp_v) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp_v, got);
    end
  endtask

  task automatic wreg(input logic [1:0] a, input logic [13:0] d,
                      input logic self_w);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    wr_self <= self_w;
    @(posedge mclk);
    wr <= 1'b0;
    wr_self <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask

  task automatic rchk(input logic [1:0] a, input logic [13:0] d,
                      input string what);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    chk(what, d, rdata);
    @(posedge mclk);
  endtask

  task automatic conclude;
    $display("checked %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    bad_count++;
    $display("run timed out");
    conclude();
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    for (n = 0; n < 8 && cfg_ready !== 1'b1; n++) @(posedge mclk);
    chk("ready", 14'h0001, {13'h0, cfg_ready});
    chk("wdog", {3'h7, 5'h0b, 5'h10, 1'b1}, wd_v);
    chk("clk", 14'h0000, ck_v);
    chk("boot", 14'h0000, bb_v);
    chk("memf", 14'h0060, mf_v);
    rchk(2'h0, 14'h3fff, "wword");
    rchk(2'h1, 14'h3fff, "mword");
    $display("test defaults done");
    wreg(2'h2, 14'h00a5, 1'b0);
    chk("wdog", {3'h2, 5'h12, 5'h17, 1'b1}, wd_v);
    wreg(2'h2, 14'h0aa7, 1'b0);
    chk("wdog", {3'h2, 5'h13, 5'h05, 1'b1}, wd_v);
    chk("clk", 14'h0005, ck_v);
    $display("test soft fields done");
    for (m = 0; m < 4; m++)
      for (s = 0; s < 2; s++)
        for (e = 0; e < 2; e++) begin
          sleep <= s[0];
          wreg(2'h2, 14'h0aa6 | 14'(e), 1'b0);
          wreg(2'h0, 14'h3f9f | 14'(m << 5), 1'b0);
          x = (m == 3) || (m == 2 && s == 0) || (m == 1 && e == 1);
          chk("run", {13'h0, x}, {13'h0, wdog_run});
        end
    sleep <= 1'b0;
    for (c = 0; c < 8; c++) begin
      wreg(2'h0, 14'h07ff | 14'(c << 11), 1'b0);
      ex = (c == 7) ? 14'h0005 : 14'(c);
      if (c > 1 && c < 7) ex[3] = 1'b1;
      chk("clk", ex, ck_v);
    end
    $display("test modes and clocks done");
    wreg(2'h1, 14'h3eff, 1'b0);
    chk("boot", 14'h0000, bb_v);
    wreg(2'h1, 14'h3ef7, 1'b0);
    chk("boot", 14'h3200, bb_v);
    chk("last", 14'h01ff, {2'h0, boot_block_last});
    wreg(2'h1, 14'h3ff8, 1'b0);
    rchk(2'h1, 14'h3ef7, "mword");
    bulk_erase <= 1'b1;
    @(posedge mclk);
    bulk_erase <= 1'b0;
    rchk(2'h1, 14'h3fff, "mword");
    wreg(2'h1, 14'h3ff0, 1'b0);
    chk("boot", 14'h2400, bb_v);
    lvp_prog_active <= 1'b1;
    wreg(2'h1, 14'h156f, 1'b0);
    chk("memf", 14'h006f, mf_v);
    lvp_prog_active <= 1'b0;
    wreg(2'h1, 14'h156f, 1'b0);
    chk("memf", 14'h001f, mf_v);
    wreg(2'h0, 14'h0000, 1'b1);
    rchk(2'h0, 14'h3fff, "wword");
    $display("test memory word done");
    master_clear_pin_enable <= 1'b1;
    rchk(2'h3, 14'h0015, "status");
    rchk(2'h3, 14'h0005, "status");
    chk("memf", 14'h003f, mf_v);
    wreg(2'h0, 14'h03e4, 1'b0);
    chk("key", 14'h0001, {13'h0, wdog_keyed_access});
    chk("clk", 14'h0000, ck_v);
    wreg(2'h2, 14'h0000, 1'b0);
    chk("wdog", {3'h2, 5'h13, 5'h05, 1'b1}, wd_v);
    rchk(2'h2, 14'h00a6, "ctrl");
    rchk(2'h3, 14'h0007, "status");
    $display("test locks and status done");
    conclude();
  end
endmodule
